// file: logic/sfps_params.svh
// How it works
// - write enable bit must be set first or in the same write; start of row erase or program is refused otherwise.
// - erase select bit makes the next start by a core instruction erase the addressed row; a 1111 start programs regardless.
// - setting the write start bit launches the selected erase or program sequence.
// - writing 0180h to key pair 3C0005h:3C0004h arms a whole-device erase.
// - whole-device erase also clears every code-protection setting.
// - whole-device erase is self-timed from fourth falling clock; serial input ignored meanwhile.
// - row erase clears one aligned 1024-byte row, refused when protected.
// - row erase runs while the no-op's fourth clock is held high.
// - falling clock after the hold ends the sequence; programmer then holds it low.
// - row erased is the one containing the table pointer, any byte within.
// - row erase never clears code protection.
// - 64-byte write buffer programs the aligned region under the table pointer.
// - write buffer keeps its contents after programming; programmer reloads only the words it changes.
// - 1101 writes two bytes and adds 2; 1111 writes two bytes and starts.
// - after 1111 the no-op's fourth clock held high sets the program time.
// - 4-bit command then 16-bit operand, latched on falling clock, LSb first.
// - command 0000 passes its operand to the core as an instruction.
// - table pointer is upper[5:0], high and low bytes, 22 bits.
`ifndef SFPS_PARAMS_SVH
`define SFPS_PARAMS_SVH

`define SFPS_CMD_CORE       4'h0
`define SFPS_CMD_TBLWR      4'hc
`define SFPS_CMD_TBLWR_INC  4'hd
`define SFPS_CMD_TBLWR_PROG 4'hf

`define SFPS_LAST_BIT       5'h13
`define SFPS_HOLD_BIT       5'h03

`define SFPS_OPC_LOAD_LITERAL_INSTR      8'h0e
`define SFPS_OPC_STORE_WORKING_INSTR      7'h37
`define SFPS_OPC_CLEAR_FILE_INSTR       7'h35
`define SFPS_OPC_BSF        4'h8
`define SFPS_OPC_BCF        4'h9

`define SFPS_FILE_TBLU      8'hf8
`define SFPS_FILE_TBLH      8'hf7
`define SFPS_FILE_TBLL      8'hf6
`define SFPS_FILE_NVMCON    8'ha6

`define SFPS_BIT_WR         1
`define SFPS_BIT_WRITE_ENABLE_BIT       2
`define SFPS_BIT_FREE       4

`define SFPS_KEY_LOW_ADDR   22'h3c0004
`define SFPS_KEY_HIGH_ADDR  22'h3c0005
`define SFPS_BULK_KEY       16'h0180
`define SFPS_TBL_STEP       22'h000002

`define SFPS_BUF_WORDS      6'h20
`define SFPS_FIFO_DEPTH     16

`define SFPS_MCLK_PERIOD_NS 25
`define SFPS_BULK_ERASE_NS  5000000
`define SFPS_BULK_ERASE_CYCLES ((`SFPS_BULK_ERASE_NS + `SFPS_MCLK_PERIOD_NS - 1) / `SFPS_MCLK_PERIOD_NS)

`endif

// file: logic/sfps_pkg.sv
package sfps_pkg;

    typedef enum logic [1:0] {
        SFPS_IDLE  = 2'b00,
        SFPS_ARMED = 2'b01,
        SFPS_HOLD  = 2'b10,
        SFPS_BULK  = 2'b11
    } sfps_state_t;

    typedef enum logic [1:0] {
        SFPS_OP_NONE = 2'b00,
        SFPS_OP_ROW  = 2'b01,
        SFPS_OP_PROG = 2'b10,
        SFPS_OP_ALL  = 2'b11
    } sfps_flash_op_t;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
    } sfps_word_t;

endpackage

// file: logic/sfps_fifo.sv
module sfps_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } sfps_fifo_state_t;

    sfps_fifo_state_t q;
    sfps_fifo_state_t d;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign count       = q.wp - q.rp;
    assign in_ready_o  = (count != (AW + 1)'(DEPTH));
    assign out_valid_o = (q.wp != q.rp);
    assign out_data_o  = q.mem[q.rp[AW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp[AW-1:0]] = in_data_i;
            d.wp                = q.wp + (AW + 1)'(1);
        end
        if (pop) begin
            d.rp = q.rp + (AW + 1)'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    fifo_bound_a: assert property (count <= (AW + 1)'(DEPTH))
        else $error("fifo holds more words than its depth");
    fifo_full_stall_a: assert property (!in_ready_o && !pop |=> $stable(count) && !in_ready_o)
        else $error("full fifo accepted a word");
    fifo_push_count_a: assert property (push && !pop |=> count == $past(count) + (AW + 1)'(1))
        else $error("accepted word not counted");
endmodule

// file: logic/sfps_seq.sv
`include "sfps_params.svh"

module sfps_seq #(
    parameter int unsigned BULK_ERASE_CYCLES = `SFPS_BULK_ERASE_CYCLES
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  prog_clock_pin_i,
    input  wire logic                  prog_data_pin_i,
    output logic                       prog_data_pin_o,
    output logic                       prog_data_pin_oe_n_o,
    input  wire logic                  code_protect_i,
    input  wire logic                  write_protect_i,
    output logic [15:0]                core_instr_o,
    output logic                       core_instr_valid_o,
    output logic [7:0]                 nvm_control_o,
    output logic [21:0]                table_pointer_o,
    output sfps_pkg::sfps_flash_op_t   flash_op_o,
    output logic [21:0]                flash_addr_o,
    output logic                       flash_hv_o,
    output logic                       protect_clear_o,
    output sfps_pkg::sfps_word_t       flash_word_o,
    output logic                       flash_word_valid_o,
    input  wire logic                  flash_word_ready_i,
    output logic                       busy_o
);
    typedef struct packed {
        logic                     ck1;
        logic                     ck2;
        logic                     ck3;
        logic                     dt1;
        logic                     dt2;
        logic [19:0]              sr;
        logic [4:0]               nbit;
        sfps_pkg::sfps_state_t    st;
        sfps_pkg::sfps_flash_op_t op;
        logic [7:0]               wreg;
        logic [7:0]               tblu;
        logic [7:0]               tblh;
        logic [7:0]               tbll;
        logic [7:0]               nvm;
        logic [7:0]               key_hi;
        logic                     key_ok;
        logic [21:0]              op_addr;
        logic [31:0][15:0]        wbuf;
        logic [5:0]               push_idx;
        logic [31:0]              cnt;
        logic [15:0]              core_instr;
        logic                     core_vld;
        logic                     pclr;
    } sfps_seq_state_t;

    sfps_seq_state_t      q;
    sfps_seq_state_t      d;
    logic                 rise;
    logic                 fall;
    logic                 exec;
    logic [19:0]          sr_n;
    logic [3:0]           cmd;
    logic [15:0]          opd;
    logic [21:0]          tbl;
    logic [21:0]          tbl_inc;
    logic [7:0]           mv_val;
    logic                 prot;
    logic                 push_vld;
    logic                 push_rdy;
    sfps_pkg::sfps_word_t push_word;

    // edges seen on the twice-synchronised link clock
    assign rise    = q.ck2 & ~q.ck3;
    assign fall    = ~q.ck2 & q.ck3;
    assign sr_n    = {q.dt2, q.sr[19:1]};
    assign exec    = fall && (q.st != sfps_pkg::SFPS_BULK) && (q.nbit == `SFPS_LAST_BIT);
    assign cmd     = sr_n[3:0];
    assign opd     = sr_n[19:4];
    assign tbl     = {q.tblu[5:0], q.tblh, q.tbll};
    assign tbl_inc = tbl + `SFPS_TBL_STEP;
    assign mv_val  = (opd[15:9] == `SFPS_OPC_STORE_WORKING_INSTR) ? q.wreg : 8'h00;
    assign prot    = code_protect_i | write_protect_i;

    // buffer words stream to the array during the timed high phase
    assign push_vld       = (q.st == sfps_pkg::SFPS_HOLD) && (q.op == sfps_pkg::SFPS_OP_PROG)
                            && (q.push_idx != `SFPS_BUF_WORDS);
    assign push_word.addr = q.op_addr | {16'h0000, q.push_idx[4:0], 1'b0};
    assign push_word.data = q.wbuf[q.push_idx[4:0]];

    always_comb begin
        d          = q;
        d.ck1      = prog_clock_pin_i;
        d.ck2      = q.ck1;
        d.ck3      = q.ck2;
        d.dt1      = prog_data_pin_i;
        d.dt2      = q.dt1;
        d.core_vld = 1'b0;
        d.pclr     = 1'b0;

        // serial input is dead while the self-timed erase runs
        if (fall && q.st != sfps_pkg::SFPS_BULK) begin
            d.sr   = sr_n;
            d.nbit = q.nbit + 5'h01;
        end

        if (exec) begin
            d.nbit = 5'h00;
            case (cmd)
                `SFPS_CMD_CORE: begin
                    d.core_instr = opd;
                    d.core_vld   = 1'b1;
                    if (opd[15:8] == `SFPS_OPC_LOAD_LITERAL_INSTR) begin
                        d.wreg = opd[7:0];
                    end else if (opd[15:9] == `SFPS_OPC_STORE_WORKING_INSTR || opd[15:9] == `SFPS_OPC_CLEAR_FILE_INSTR) begin
                        case (opd[7:0])
                            `SFPS_FILE_TBLU:   d.tblu = {2'b00, mv_val[5:0]};
                            `SFPS_FILE_TBLH:   d.tblh = mv_val;
                            `SFPS_FILE_TBLL:   d.tbll = mv_val;
                            `SFPS_FILE_NVMCON: d.nvm  = mv_val;
                            default: ;
                        endcase
                    end else if ((opd[15:12] == `SFPS_OPC_BSF || opd[15:12] == `SFPS_OPC_BCF)
                                 && opd[7:0] == `SFPS_FILE_NVMCON) begin
                        d.nvm[opd[11:9]] = (opd[15:12] == `SFPS_OPC_BSF);
                    end
                    // write start bit just set: launch or refuse
                    if (d.nvm[`SFPS_BIT_WR] && !q.nvm[`SFPS_BIT_WR]) begin
                        if (q.st == sfps_pkg::SFPS_IDLE && d.nvm[`SFPS_BIT_WRITE_ENABLE_BIT]
                            && !(d.nvm[`SFPS_BIT_FREE] && prot)) begin
                            d.st = sfps_pkg::SFPS_ARMED;
                            if (d.nvm[`SFPS_BIT_FREE]) begin
                                d.op      = sfps_pkg::SFPS_OP_ROW;
                                d.op_addr = {tbl[21:10], 10'h000};
                            end else begin
                                d.op      = sfps_pkg::SFPS_OP_PROG;
                                d.op_addr = {tbl[21:6], 6'h00};
                            end
                        end else begin
                            d.nvm[`SFPS_BIT_WR] = 1'b0;
                        end
                    end
                end
                `SFPS_CMD_TBLWR: begin
                    if (tbl == `SFPS_KEY_HIGH_ADDR) begin
                        d.key_hi = opd[7:0];
                        d.key_ok = 1'b0;
                    end else if (tbl == `SFPS_KEY_LOW_ADDR) begin
                        d.key_ok = ({q.key_hi, opd[7:0]} == `SFPS_BULK_KEY);
                    end
                end
                `SFPS_CMD_TBLWR_INC: begin
                    d.wbuf[tbl[5:1]] = opd;
                    d.tblu = {2'b00, tbl_inc[21:16]};
                    d.tblh = tbl_inc[15:8];
                    d.tbll = tbl_inc[7:0];
                end
                `SFPS_CMD_TBLWR_PROG: begin
                    d.wbuf[tbl[5:1]] = opd;
                    if (q.st == sfps_pkg::SFPS_IDLE && q.nvm[`SFPS_BIT_WRITE_ENABLE_BIT]) begin
                        d.st                = sfps_pkg::SFPS_ARMED;
                        d.op                = sfps_pkg::SFPS_OP_PROG;
                        d.op_addr           = {tbl[21:6], 6'h00};
                        d.nvm[`SFPS_BIT_WR] = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // fourth clock of the following command opens the timed window
        if (rise && q.st == sfps_pkg::SFPS_ARMED && q.nbit == `SFPS_HOLD_BIT) begin
            d.st       = sfps_pkg::SFPS_HOLD;
            d.push_idx = 6'h00;
        end
        if (q.st == sfps_pkg::SFPS_HOLD && push_vld && push_rdy) begin
            d.push_idx = q.push_idx + 6'h01;
        end
        if (fall && q.st == sfps_pkg::SFPS_HOLD) begin
            d.st                = sfps_pkg::SFPS_IDLE;
            d.op                = sfps_pkg::SFPS_OP_NONE;
            d.nvm[`SFPS_BIT_WR] = 1'b0;
        end

        if (fall && q.st == sfps_pkg::SFPS_IDLE && q.key_ok && q.nbit == `SFPS_HOLD_BIT) begin
            d.st      = sfps_pkg::SFPS_BULK;
            d.op      = sfps_pkg::SFPS_OP_ALL;
            d.op_addr = 22'h000000;
            d.cnt     = 32'h00000000;
            d.key_ok  = 1'b0;
            d.pclr    = 1'b1;
        end
        if (q.st == sfps_pkg::SFPS_BULK) begin
            d.cnt = q.cnt + 32'h00000001;
            if (q.cnt == 32'(BULK_ERASE_CYCLES - 1)) begin
                d.st   = sfps_pkg::SFPS_IDLE;
                d.op   = sfps_pkg::SFPS_OP_NONE;
                d.nbit = 5'h00;
                d.sr   = 20'h00000;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    sfps_fifo #(
        .WIDTH ($bits(sfps_pkg::sfps_word_t)),
        .DEPTH (`SFPS_FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .in_data_i   (push_word),
        .in_valid_i  (push_vld),
        .in_ready_o  (push_rdy),
        .out_data_o  (flash_word_o),
        .out_valid_o (flash_word_valid_o),
        .out_ready_i (flash_word_ready_i)
    );

    // data pin is input only for erase and program traffic
    assign prog_data_pin_o      = 1'b0;
    assign prog_data_pin_oe_n_o = 1'b1;
    assign core_instr_o         = q.core_instr;
    assign core_instr_valid_o   = q.core_vld;
    assign nvm_control_o        = q.nvm;
    assign table_pointer_o      = tbl;
    assign flash_hv_o           = (q.st == sfps_pkg::SFPS_HOLD) || (q.st == sfps_pkg::SFPS_BULK);
    assign flash_op_o           = flash_hv_o ? q.op : sfps_pkg::SFPS_OP_NONE;
    assign flash_addr_o         = q.op_addr;
    assign protect_clear_o      = q.pclr;
    assign busy_o               = (q.st != sfps_pkg::SFPS_IDLE);

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    write_enable_bit_guard_a: assert property ($rose(q.st == sfps_pkg::SFPS_ARMED) |-> q.nvm[`SFPS_BIT_WRITE_ENABLE_BIT])
        else $error("operation armed without write enable");
    erase_select_a: assert property ($rose(q.st == sfps_pkg::SFPS_ARMED) && q.nvm[`SFPS_BIT_FREE]
                                     && q.op != sfps_pkg::SFPS_OP_PROG |-> q.op == sfps_pkg::SFPS_OP_ROW)
        else $error("erase select did not choose row erase");
    bulk_key_start_a: assert property (fall && q.st == sfps_pkg::SFPS_IDLE && q.key_ok
                                       && q.nbit == `SFPS_HOLD_BIT |=> flash_op_o == sfps_pkg::SFPS_OP_ALL)
        else $error("armed key did not start whole erase");
    bulk_clear_prot_a: assert property ($rose(flash_op_o == sfps_pkg::SFPS_OP_ALL) |-> protect_clear_o)
        else $error("whole erase without protection clear");
    bulk_serial_mute_a: assert property (q.st == sfps_pkg::SFPS_BULK && !$rose(q.st == sfps_pkg::SFPS_BULK)
                                         |-> $stable(q.nbit) && !core_instr_valid_o)
        else $error("serial input taken during whole erase");
    bulk_length_a: assert property (q.st == sfps_pkg::SFPS_BULK |-> q.cnt < 32'(BULK_ERASE_CYCLES))
        else $error("whole erase ran past its time");
    row_align_a: assert property (flash_op_o == sfps_pkg::SFPS_OP_ROW |-> flash_addr_o[9:0] == 10'h000)
        else $error("row erase address not row aligned");
    row_keep_prot_a: assert property (protect_clear_o |-> q.op == sfps_pkg::SFPS_OP_ALL)
        else $error("protection cleared outside whole erase");
    hold_start_a: assert property (rise && q.st == sfps_pkg::SFPS_ARMED && q.nbit == `SFPS_HOLD_BIT
                                   |=> flash_hv_o ##0 flash_op_o != sfps_pkg::SFPS_OP_NONE)
        else $error("fourth clock high did not open the window");
    hold_end_a: assert property (fall && q.st == sfps_pkg::SFPS_HOLD
                                 |=> !flash_hv_o && !nvm_control_o[`SFPS_BIT_WR])
        else $error("falling clock did not end the sequence");
    prog_region_a: assert property (flash_op_o == sfps_pkg::SFPS_OP_PROG |-> flash_addr_o[5:0] == 6'h00)
        else $error("program region not aligned");
    tbl_step_a: assert property (exec && cmd == `SFPS_CMD_TBLWR_INC
                                 |=> table_pointer_o == $past(tbl_inc))
        else $error("table pointer not advanced by two");
    core_pass_a: assert property (exec && cmd == `SFPS_CMD_CORE
                                  |=> core_instr_valid_o && core_instr_o == $past(opd))
        else $error("core instruction not passed on");

    // launch and refusal
    wr_busy_a: assert property (nvm_control_o[`SFPS_BIT_WR]
                                |-> busy_o)
        else $error("write start bit left set while idle");

    arm_sets_wr_a: assert property ($rose(q.st == sfps_pkg::SFPS_ARMED)
                                    |-> q.nvm[`SFPS_BIT_WR])
        else $error("armed without write start bit");

    row_prot_a: assert property ($rose(q.st == sfps_pkg::SFPS_ARMED) && q.op == sfps_pkg::SFPS_OP_ROW
                                 |-> !$past(prot))
        else $error("protected row armed for erase");

    row_base_a: assert property ($rose(q.st == sfps_pkg::SFPS_ARMED) && q.op == sfps_pkg::SFPS_OP_ROW
                                 |-> q.op_addr == {$past(tbl[21:10]), 10'h000})
        else $error("row base not taken from table pointer");

    prog_arm_a: assert property (exec && cmd == `SFPS_CMD_TBLWR_PROG && q.st == sfps_pkg::SFPS_IDLE
                                 && q.nvm[`SFPS_BIT_WRITE_ENABLE_BIT] |=> q.st == sfps_pkg::SFPS_ARMED && q.op == sfps_pkg::SFPS_OP_PROG)
        else $error("start programming did not arm");

    prog_refuse_a: assert property (exec && cmd == `SFPS_CMD_TBLWR_PROG && q.st == sfps_pkg::SFPS_IDLE
                                    && !q.nvm[`SFPS_BIT_WRITE_ENABLE_BIT] |=> !busy_o)
        else $error("programming started without write enable");

    // timed window
    hold_from_arm_a: assert property ($rose(q.st == sfps_pkg::SFPS_HOLD)
                                      |-> $past(q.st) == sfps_pkg::SFPS_ARMED)
        else $error("window opened without an armed operation");

    hold_keep_a: assert property (q.st == sfps_pkg::SFPS_HOLD && !fall
                                  |=> q.st == sfps_pkg::SFPS_HOLD)
        else $error("window closed while clock still high");

    push_first_a: assert property ($rose(q.st == sfps_pkg::SFPS_HOLD) && q.op == sfps_pkg::SFPS_OP_PROG
                                   |-> push_vld && push_word.addr == q.op_addr)
        else $error("first buffer word not at region base");

    buf_keep_a: assert property (!(exec && (cmd == `SFPS_CMD_TBLWR_INC || cmd == `SFPS_CMD_TBLWR_PROG))
                                 |=> $stable(q.wbuf))
        else $error("write buffer changed without a table write");

    // whole erase
    key_arm_a: assert property (exec && cmd == `SFPS_CMD_TBLWR && tbl == `SFPS_KEY_LOW_ADDR
                                && {q.key_hi, opd[7:0]} == `SFPS_BULK_KEY |=> q.key_ok)
        else $error("key pair did not arm whole erase");

    bulk_end_a: assert property (q.st == sfps_pkg::SFPS_BULK && q.cnt == 32'(BULK_ERASE_CYCLES - 1)
                                 |=> !busy_o && q.nbit == 5'h00)
        else $error("whole erase did not end cleanly");

    // serial framing
    bit_count_a: assert property (fall && q.st != sfps_pkg::SFPS_BULK && q.nbit != `SFPS_LAST_BIT
                                  |=> q.nbit == $past(q.nbit) + 5'h01)
        else $error("latched bit not counted");

    core_load_a: assert property (exec && cmd == `SFPS_CMD_CORE
                                  && opd == {`SFPS_OPC_STORE_WORKING_INSTR, 1'b0, `SFPS_FILE_TBLL} |=> q.tbll == $past(q.wreg))
        else $error("pointer low byte not loaded");

    core_pulse_a: assert property (core_instr_valid_o
                                   |=> !core_instr_valid_o)
        else $error("core instruction strobe longer than a cycle");
endmodule

// file: test/sfps_programmer.sv
module sfps_programmer #(
    parameter int HALF_NS      = 100,
    parameter int DISCHARGE_NS = 400
) (
    output logic clk_o,
    output logic dat_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        clk_o = 1'b0;
        dat_o = 1'b0;
    end

    // command nibble then operand, lsb first
    task automatic send(input logic [3:0] cmd, input logic [15:0] opnd, input int hold_ns, input int nbits);
        logic [19:0] v;
        v = {opnd, cmd};
        for (int i = 0; i < nbits; i++) begin
            clk_o = 1'b1;
            dat_o = v[i];
            #(HALF_NS);
            if (i == 3) #(hold_ns);
            clk_o = 1'b0;
            #(HALF_NS);
            if (i == 3 && hold_ns > 0) #(DISCHARGE_NS);
        end
        // released line shows the inverse, except held low through a whole erase
        if (nbits == 20) dat_o = ~dat_o;
    endtask
endmodule

// file: test/test_serial_flash_erase_program_sequencer.sv
module test_serial_flash_erase_program_sequencer;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BULK = 50;
    localparam int HOLD = 3000;

    logic                     mclk_i, rstn_i, pclk, pdat, cp, wp, rdy, dout, oe_n, cvalid, hv, pclr, wvalid, busy;
    logic [15:0]              cinstr;
    logic [7:0]               nvm;
    logic [21:0]              tptr, faddr, last_addr;
    sfps_pkg::sfps_flash_op_t fop, last_op;
    sfps_pkg::sfps_word_t     word;
    sfps_pkg::sfps_word_t     got [0:63];
    int                       n_hv, n_clr, n_w, n_cv, num_errors, n_compared;
    wire                      dat_w = oe_n ? pdat : dout;

    initial mclk_i = 1'b0;
    always #12.5 mclk_i = ~mclk_i;

    sfps_programmer i_prog (.clk_o(pclk), .dat_o(pdat));

    sfps_seq #(.BULK_ERASE_CYCLES(BULK)) i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .prog_clock_pin_i(pclk), .prog_data_pin_i(dat_w),
        .prog_data_pin_o(dout), .prog_data_pin_oe_n_o(oe_n), .code_protect_i(cp), .write_protect_i(wp),
        .core_instr_o(cinstr), .core_instr_valid_o(cvalid), .nvm_control_o(nvm), .table_pointer_o(tptr),
        .flash_op_o(fop), .flash_addr_o(faddr), .flash_hv_o(hv), .protect_clear_o(pclr),
        .flash_word_o(word), .flash_word_valid_o(wvalid), .flash_word_ready_i(rdy), .busy_o(busy)
    );

    // sink stalls every other cycle
    always @(posedge mclk_i) rdy <= #2 ~rdy;

    always @(posedge mclk_i) begin
        if (rstn_i) begin
            if (hv) begin
                n_hv++;
                last_op = fop;
                last_addr = faddr;
            end
            if (pclr) n_clr++;
            if (cvalid) n_cv++;
            if (wvalid && rdy && n_w < 64) begin
                got[n_w] = word;
                n_w++;
            end
        end
    end

    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("mismatches %0d of %0d compared", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic core(input logic [15:0] opnd);
        i_prog.send(4'h0, opnd, 0, 20);
    endtask

    task automatic settle;
        repeat (4) @(posedge mclk_i);
        #2;
    endtask

    task automatic set_ptr(input logic [21:0] a);
        core({8'h0e, 2'b00, a[21:16]});
        core(16'h6ef8);
        core({8'h0e, a[15:8]});
        core(16'h6ef7);
        core({8'h0e, a[7:0]});
        core(16'h6ef6);
    endtask

    task automatic clr_mon;
        n_hv = 0;
        n_clr = 0;
        n_w = 0;
        n_cv = 0;
    endtask

    // start from 1111 and compare every word that reached the sink
    task automatic run_prog(input logic [15:0] last);
        clr_mon();
        i_prog.send(4'hf, last, 0, 20);
        i_prog.send(4'h0, 16'h0000, HOLD, 20);
        settle();
        check(38'(last_op), 38'(sfps_pkg::SFPS_OP_PROG));
        check(38'(n_w), 38'd32);
        for (int i = 0; i < 32; i++) begin
            check(got[i], {22'h000040 + 22'(2 * i), (i == 31) ? last : 16'ha500 + 16'(i)});
        end
    endtask

    initial begin
        rstn_i = 1'b0;
        cp = 1'b0;
        wp = 1'b0;
        rdy = 1'b0;
        clr_mon();
        num_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge mclk_i);
        #2 rstn_i = 1'b1;
        settle();
        check(38'({dout, oe_n, busy, nvm, tptr}), 38'({1'b0, 1'b1, 1'b0, 8'h00, 22'h000000}));
        core(16'h84a6);
        settle();
        check(38'(cinstr), 38'h84a6);
        check(38'(nvm[2]), 38'h1);
        check(38'(n_cv), 38'h1);
        set_ptr(22'h010a37);
        settle();
        check(38'(tptr), 38'h010a37);
        core(16'h88a6);
        for (int p = 1; p < 3; p++) begin
            {cp, wp} = 2'(p);
            core(16'h82a6);
            settle();
            check(38'({busy, nvm[1]}), 38'h0);
        end
        {cp, wp} = 2'b00;
        core(16'h94a6);
        core(16'h82a6);
        settle();
        check(38'({busy, nvm}), 38'h010);
        core(16'h84a6);
        core(16'h82a6);
        settle();
        check(38'(busy), 38'h1);
        clr_mon();
        i_prog.send(4'h0, 16'h0000, HOLD, 20);
        settle();
        check(38'(last_op), 38'(sfps_pkg::SFPS_OP_ROW));
        // row erase must leave code protection alone, so no clear pulse
        check(38'(last_addr), 38'h010800);
        check(38'(n_clr), 38'h0);
        check(38'({busy, nvm}), 38'h014);
        core(16'h98a6);
        set_ptr(22'h000040);
        for (int i = 0; i < 31; i++) i_prog.send(4'hd, 16'ha500 + 16'(i), 0, 20);
        settle();
        check(38'(tptr), 38'h00007e);
        run_prog(16'ha51f);
        core(16'h88a6);
        core(16'h82a6);
        clr_mon();
        i_prog.send(4'h0, 16'h0000, HOLD, 20);
        settle();
        check(38'({last_op, last_addr}), 38'({sfps_pkg::SFPS_OP_ROW, 22'h000000}));
        core(16'h98a6);
        set_ptr(22'h00007e);
        run_prog(16'h5a5a);
        set_ptr(22'h3c0005);
        i_prog.send(4'hc, 16'h0101, 0, 20);
        set_ptr(22'h3c0004);
        i_prog.send(4'hc, 16'h8080, 0, 20);
        clr_mon();
        i_prog.send(4'h0, 16'h0000, 0, 4);
        i_prog.send(4'h0, 16'h0000, 0, 4);
        repeat (BULK + 10) @(posedge mclk_i);
        #2;
        check(38'(last_op), 38'(sfps_pkg::SFPS_OP_ALL));
        check(38'(n_hv), 38'(BULK));
        check(38'(n_clr), 38'h1);
        check(38'(busy), 38'h0);
        check(38'(n_cv), 38'h0);
        core(16'h94a6);
        settle();
        check(38'({cinstr, nvm}), 38'h94a600);
        wrap_up();
    end

    initial begin
        #2ms;
        num_errors++;
        wrap_up();
    end
endmodule
